// ### rtl/fdnr_fifo.sv
// Purpose: Field FIFO read port, write capture, test mode and denoise control
// Assumes: Link clocks and strobes are slow pins sampled by clk_i at 125 MHz
// Notes:   Registers over Avalon-MM, one wait state per access
// How it works
// RULE1: Output word shifts on read clock edge when advance and drive are both high.
// RULE2: Output bus driven while drive strobe high, released otherwise.
// RULE3: Output words keep the exact bit polarity of captured input words.
// RULE4: Read pointer steps once per read clock edge with advance high, else holds.
// RULE5: Drive strobe never affects read pointer stepping.
// RULE6: Controller waits 100 us after power-up before initialising.
// RULE7: Controller gives 12 dummy clocks then a pointer clear on each side.
// RULE8: Early initialisation is repeated later, starting with extra clears.
// RULE9: Controller allows 40 write clocks before expecting new data back.
// RULE10: Read clear within 20 write clocks of write clear returns old field.
// RULE11: Controller avoids pointer distances above 20 and below 40.
// RULE12: Block access modes keep the 40 write clock delay per block.
// RULE13: Oscillator-driven arbiter schedules write, read and refresh with counters.
// RULE14: Test mode after 1024 cycles of both high; exit on one or two lows.
// RULE15: Denoise enable starts noise reduction from default settings.
// RULE16: Denoise disabled passes input words unchanged into the FIFO.
// RULE17: Controller halves the write clock rate while denoise is on.
// RULE18: A control bit stops automatic refresh.
// RULE19: Fixed weights selectable separately for chroma and luma.
// RULE20: Adaptive weight from difference magnitude through programmable steps.
// RULE21: Chroma follows luma weight when the slave bit is set; the code does so only while the chroma fixed-weight bit is clear.
// RULE22: Band control picks low band only or full band for averaging.
// RULE23: Read clear sets pointer to lowest address, deferred until advance high.
// RULE24: Weight one gives new, zero gives old, between blends proportionally.
`timescale 1ns/1ns
module fdnr_fifo #(
  parameter int ARRAY_WORDS = fdnr_pkg::ARRAY_WORDS,
  parameter int REF_DIV     = fdnr_pkg::REF_OSC_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        serial_write_clock_i,
  input  wire logic        wr_en_i,
  input  wire logic        in_en_i,
  input  wire logic        wr_ptr_clear_i,
  input  wire logic [11:0] in_bus_i,
  input  wire logic        denoise_on_i,
  input  wire logic        serial_read_clock_i,
  input  wire logic        rd_advance_en_i,
  input  wire logic        out_drive_i,
  input  wire logic        rd_ptr_clear_i,
  output logic      [11:0] out_bus_o,
  output logic             out_bus_oe_o,
  output logic             test_mode_o
);
  localparam int W     = fdnr_pkg::WORD_W;
  localparam int CW    = fdnr_pkg::CACHE_WORDS;
  localparam int DEPTH = CW + ARRAY_WORDS;
  localparam int AW    = $clog2(DEPTH);
  localparam int LAT   = fdnr_pkg::NEW_DATA_LAT;
  localparam int BLKS  = ARRAY_WORDS / fdnr_pkg::BLOCK_WORDS;
  localparam int RW    = $clog2(BLKS);
  localparam int OW    = $clog2(REF_DIV + 1);
  localparam int NP    = W + 9;
  // Pin positions in the sampled vector
  localparam int P_WCK  = 0;
  localparam int P_WEN  = 1;
  localparam int P_IEN  = 2;
  localparam int P_WCLR = 3;
  localparam int P_RCK  = 4;
  localparam int P_ADV  = 5;
  localparam int P_DRV  = 6;
  localparam int P_RCLR = 7;
  localparam int P_DEN  = 8;
  localparam int P_D    = 9;

  // Refuse geometries the pointer and block logic cannot serve
  if (ARRAY_WORDS % fdnr_pkg::BLOCK_WORDS != 0 || BLKS < 2 || REF_DIV < 2) begin : g_bad
    $error("fdnr_fifo: ARRAY_WORDS or REF_DIV out of range");
  end

  typedef struct packed {
    logic [NP-1:0]            s1;
    logic [NP-1:0]            s2;
    logic [NP-1:0]            s3;
    logic [AW-1:0]            wr_ptr;
    logic [AW-1:0]            rd_ptr;
    logic                     wclr_pend;
    logic                     rclr_pend;
    logic [LAT-1:0][AW+W:0]   pipe;
    logic [10:0]              test_cnt;
    logic [1:0]               wclr_low;
    logic                     test_mode;
    logic signed [9:0]        ydiff;
    logic signed [9:0]        cdiff;
    logic [fdnr_pkg::CTRL_W-1:0] ctrl;
    logic [7:0]               kfix;
    logic [31:0]              kstep;
    logic [OW-1:0]            osc;
    logic                     ref_pend;
    logic [RW-1:0]            ref_ctr;
    logic [W-1:0]             q;
    logic                     oe;
    logic [31:0]              rdata;
    logic                     wait_r;
  } fdnr_state_t;

  fdnr_state_t   r, n;
  logic [W-1:0]  mem [DEPTH];
  logic [NP-1:0] lv;
  logic          wr_edge, rd_edge, wclr_rise, rclr_rise, den_rise;
  logic          push, commit, tick;
  logic [W-1:0]  din, rd_word, old_word, nr_word, push_data;
  logic signed [9:0] ydiff_n, cdiff_n;
  logic [4:0]    ky, kc;
  logic [AW-1:0] wr_at, rd_at;

  // Step a pointer, wrapping past the array end to array address zero
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? AW'(CW) : p + 1'b1;
  endfunction

  // Edges and levels come from the second and third sampling stages only
  assign lv        = r.s3;
  assign wr_edge   = r.s2[P_WCK] & ~r.s3[P_WCK];
  assign rd_edge   = r.s2[P_RCK] & ~r.s3[P_RCK];
  assign wclr_rise = r.s2[P_WCLR] & ~r.s3[P_WCLR];
  assign rclr_rise = r.s2[P_RCLR] & ~r.s3[P_RCLR];
  assign den_rise  = r.s2[P_DEN] & ~r.s3[P_DEN];
  assign din       = lv[P_D +: W];
  // A pending clear makes its edge use the lowest address itself
  assign wr_at     = r.wclr_pend ? '0 : r.wr_ptr;
  assign rd_at     = r.rclr_pend ? '0 : r.rd_ptr; // RULE23
  assign rd_word   = mem[rd_at];
  assign old_word  = mem[wr_at];                  // Second fetch of the old field
  assign push      = wr_edge & lv[P_WEN] & lv[P_IEN];
  assign commit    = wr_edge & r.pipe[LAT-1][AW+W];
  assign tick      = (r.osc == OW'(REF_DIV - 1));
  assign push_data = lv[P_DEN] ? nr_word : din;   // RULE16 RULE3

  fdnr_blend u_blend (
    .new_i     (din),
    .old_i     (old_word),
    .ctrl_i    (r.ctrl),
    .kfix_i    (r.kfix),
    .kstep_i   (r.kstep),
    .yprev_i   (r.ydiff),
    .cprev_i   (r.cdiff),
    .mix_o     (nr_word),
    .ydiff_o   (ydiff_n),
    .cdiff_o   (cdiff_n),
    .kluma_o   (ky),
    .kchroma_o (kc)
  );

  // Next state of the whole block
  always_comb begin
    n    = r;
    n.s1 = {in_bus_i, denoise_on_i, rd_ptr_clear_i, out_drive_i, rd_advance_en_i,
            serial_read_clock_i, wr_ptr_clear_i, in_en_i, wr_en_i, serial_write_clock_i};
    n.s2 = r.s1;
    n.s3 = r.s2;
    // Write side: captured words wait LAT write clocks before reaching the array
    if (wr_edge) begin
      n.pipe = {r.pipe[LAT-2:0], {push, wr_at, push_data}}; // RULE10
      if (lv[P_WEN]) begin
        n.wr_ptr    = ptr_inc(wr_at);
        n.wclr_pend = 1'b0;
      end
      if (push & lv[P_DEN]) begin
        n.ydiff = ydiff_n;
        n.cdiff = cdiff_n;
      end
      // Test mode entry count and exit on write strobe or clear low
      if (lv[P_WEN] & lv[P_WCLR]) begin
        if (r.test_cnt != 11'(fdnr_pkg::TEST_ENTRY_CYC)) n.test_cnt = r.test_cnt + 11'h001;
        if (r.test_cnt == 11'(fdnr_pkg::TEST_ENTRY_CYC - 1)) n.test_mode = 1'b1; // RULE14
      end else begin
        n.test_cnt = 11'h000;
      end
      n.wclr_low = lv[P_WCLR] ? 2'h0 : ((r.wclr_low == 2'h3) ? r.wclr_low : r.wclr_low + 2'h1);
      if (!lv[P_WEN] || (!lv[P_WCLR] && r.wclr_low == 2'(fdnr_pkg::TEST_EXIT_CLR - 1))) begin
        n.test_mode = 1'b0; // RULE14
      end
    end
    if (wclr_rise) n.wclr_pend = 1'b1;
    // Read side: shift out, step pointer, deferred clear
    if (rd_edge) begin
      if (lv[P_ADV] & lv[P_DRV]) n.q = rd_word; // RULE1 RULE3
      if (lv[P_ADV]) begin                      // RULE4 RULE5
        n.rd_ptr    = ptr_inc(rd_at);           // RULE23
        n.rclr_pend = 1'b0;
      end
    end
    if (rclr_rise) n.rclr_pend = 1'b1;          // RULE23
    n.oe = lv[P_DRV];                           // RULE2
    // Refresh arbitration: refresh takes only slots with no array write
    n.osc = tick ? '0 : r.osc + 1'b1;
    if (r.ref_pend & ~commit & ~r.ctrl[fdnr_pkg::CTRL_NOREF]) begin // RULE13
      n.ref_ctr  = (r.ref_ctr == RW'(BLKS - 1)) ? '0 : r.ref_ctr + 1'b1;
      n.ref_pend = 1'b0;
    end
    if (tick) n.ref_pend = 1'b1;                // RULE13
    if (r.ctrl[fdnr_pkg::CTRL_NOREF]) n.ref_pend = 1'b0; // RULE18
    // Enabling denoise restarts from the default settings
    if (den_rise) begin                         // RULE15
      n.ctrl  = fdnr_pkg::CTRL_RST;
      n.kfix  = fdnr_pkg::KFIX_RST;
      n.kstep = fdnr_pkg::KSTEP_RST;
    end
    // Avalon slave: one wait state, read data ready when waitrequest drops
    n.wait_r = 1'b1;
    if ((avs_read_i | avs_write_i) & r.wait_r) begin
      n.wait_r = 1'b0;
      case (avs_address_i)
        fdnr_pkg::CTRL_OFS:  n.rdata = 32'(r.ctrl);
        fdnr_pkg::KFIX_OFS:  n.rdata = 32'(r.kfix);
        fdnr_pkg::KSTEP_OFS: n.rdata = r.kstep;
        fdnr_pkg::STAT_OFS: begin
          n.rdata = 32'h0000_0000;
          n.rdata[fdnr_pkg::STAT_TEST]          = r.test_mode;
          n.rdata[fdnr_pkg::STAT_DEN]           = lv[P_DEN];
          n.rdata[fdnr_pkg::STAT_REFPEND]       = r.ref_pend;
          n.rdata[fdnr_pkg::STAT_REF_LSB +: RW] = r.ref_ctr;
        end
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_i & ~r.wait_r) begin
      case (avs_address_i)
        fdnr_pkg::CTRL_OFS:  n.ctrl  = avs_writedata_i[fdnr_pkg::CTRL_W-1:0]; // RULE18
        fdnr_pkg::KFIX_OFS:  n.kfix  = avs_writedata_i[7:0];                  // RULE19
        fdnr_pkg::KSTEP_OFS: n.kstep = avs_writedata_i;                       // RULE20
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r        <= '0;
      r.ctrl   <= fdnr_pkg::CTRL_RST;
      r.kfix   <= fdnr_pkg::KFIX_RST;
      r.kstep  <= fdnr_pkg::KSTEP_RST;
      r.wait_r <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Array write from the tail of the latency line
  always_ff @(posedge clk_i) begin
    if (commit) mem[r.pipe[LAT-1][AW+W-1 -: AW]] <= r.pipe[LAT-1][W-1:0]; // RULE13
  end

  assign out_bus_o         = r.q;
  assign out_bus_oe_o      = r.oe;
  assign test_mode_o       = r.test_mode;
  assign avs_readdata_o    = r.rdata;
  assign avs_waitrequest_o = r.wait_r;

  a_out_shift: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    rd_edge && lv[P_ADV] && lv[P_DRV] |=> out_bus_o == $past(rd_word))
    else $error("output word not shifted");
  a_out_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    !(rd_edge && lv[P_ADV] && lv[P_DRV]) |=> $stable(out_bus_o))
    else $error("output word changed without shift");
  a_drive_level: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    $rose(lv[P_DRV]) |-> ##1 out_bus_oe_o ##1 (out_bus_oe_o || !lv[P_DRV]))
    else $error("bus not driven with drive strobe");
  a_rptr_hold: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    !(rd_edge && lv[P_ADV]) |=> $stable(r.rd_ptr))
    else $error("read pointer moved without advance");
  a_rptr_free: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    rd_edge && lv[P_ADV] && !lv[P_DRV] && !r.rclr_pend |=> r.rd_ptr == ptr_inc($past(r.rd_ptr)))
    else $error("read pointer stalled by drive strobe");
  a_rclr_lowest: assert property (@(posedge clk_i) disable iff (rst_i) // RULE23
    rd_edge && lv[P_ADV] && r.rclr_pend |=> r.rd_ptr == ptr_inc('0))
    else $error("read clear did not reach lowest address");
  a_bypass_word: assert property (@(posedge clk_i) disable iff (rst_i) // RULE16
    push && !lv[P_DEN] |=> r.pipe[0][W-1:0] == $past(din) && r.pipe[0][AW+W])
    else $error("bypass word altered");
  a_test_exit: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    r.test_mode && wr_edge && !lv[P_WEN] |=> !test_mode_o)
    else $error("test mode kept with write strobe low");
  a_test_entry: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
    !r.test_mode && wr_edge && lv[P_WEN] && lv[P_WCLR] && r.test_cnt == 11'h3ff |=> test_mode_o)
    else $error("test mode not entered at count");
  a_refresh_off: assert property (@(posedge clk_i) disable iff (rst_i) // RULE18
    r.ctrl[fdnr_pkg::CTRL_NOREF] |=> $stable(r.ref_ctr))
    else $error("refresh ran while disabled");
  a_chroma_slave: assert property (@(posedge clk_i) disable iff (rst_i) // RULE21
    r.ctrl[fdnr_pkg::CTRL_L2C] && !r.ctrl[fdnr_pkg::CTRL_CHROMAFIX] |-> kc == ky)
    else $error("chroma weight not slaved to luma");
  a_wait_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
endmodule // fdnr_fifo

// ### rtl/fdnr_pkg.sv
// Purpose: Shared constants for the field FIFO with denoise control
// Assumes: 32-bit Avalon-MM register words at byte offsets
// Notes:   Reset values here are what a denoise enable reloads
package fdnr_pkg;
  // Storage geometry
  localparam int WORD_W         = 12;
  localparam int CACHE_WORDS    = 12;
  localparam int ARRAY_WORDS    = 245760;
  localparam int BLOCK_WORDS    = 40;
  // Old/new data timing in write clock cycles
  localparam int NEW_DATA_LAT   = 40;
  localparam int OLD_DATA_WIN   = 20;
  // Test mode entry and exit counts in write clock cycles
  localparam int TEST_ENTRY_CYC = 1024;
  localparam int TEST_EXIT_CLR  = 2;
  // Internal oscillator divider for refresh requests
  localparam int REF_OSC_DIV    = 16;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS  = 4'h0;
  localparam logic [3:0] KFIX_OFS  = 4'h4;
  localparam logic [3:0] KSTEP_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS  = 4'hc;
  // Control register fields
  localparam int CTRL_W         = 5;
  localparam int CTRL_NOREF     = 0;
  localparam int CTRL_LUMAFIX   = 1;
  localparam int CTRL_CHROMAFIX = 2;
  localparam int CTRL_L2C       = 3;
  localparam int CTRL_UNFILT    = 4;
  // Fixed weight fields: luma low nibble, chroma high nibble
  localparam int KFIX_LUMA_LSB   = 0;
  localparam int KFIX_CHROMA_LSB = 4;
  // Status register fields
  localparam int STAT_TEST    = 0;
  localparam int STAT_DEN     = 1;
  localparam int STAT_REFPEND = 2;
  localparam int STAT_REF_LSB = 16;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST  = 5'h00;
  localparam logic [7:0]        KFIX_RST  = 8'hff;
  localparam logic [31:0]       KSTEP_RST = 32'h8765_4321;
endpackage

// ### rtl/fdnr_blend.sv
// Purpose: Field recursive blend of new and old word for luma and chroma
// Assumes: Luma in bits 11:4, chroma in bits 3:0, both straight binary
// Notes:   Purely combinational; the caller registers its results
`timescale 1ns/1ns
module fdnr_blend (
  input  wire logic        [11:0] new_i,
  input  wire logic        [11:0] old_i,
  input  wire logic        [4:0]  ctrl_i,
  input  wire logic        [7:0]  kfix_i,
  input  wire logic        [31:0] kstep_i,
  input  wire logic signed [9:0]  yprev_i,
  input  wire logic signed [9:0]  cprev_i,
  output logic             [11:0] mix_o,
  output logic signed      [9:0]  ydiff_o,
  output logic signed      [9:0]  cdiff_o,
  output logic             [4:0]  kluma_o,
  output logic             [4:0]  kchroma_o
);
  // Weight from magnitude: two sixteenths per step passed, capped at one
  function automatic logic [4:0] k_lut(input logic [8:0] mag, input logic [31:0] st);
    logic [4:0] k;
    k = 5'h00;
    for (int i = 0; i < 8; i++) begin
      if (mag >= {4'h0, st[4*i +: 4], 1'b0}) k = k + 5'h02;
    end
    return k;
  endfunction

  // Fixed weight code: top code means the whole new sample
  function automatic logic [4:0] k_fix(input logic [3:0] v);
    return (v == 4'hf) ? 5'h10 : {1'b0, v};
  endfunction

  // Old plus weighted low band plus untouched high band, clamped
  function automatic logic [7:0] mix(input logic [7:0] nw, input logic [7:0] ow,
                                     input logic [4:0] k, input logic signed [9:0] lf,
                                     input logic [7:0] mx);
    logic signed [9:0]  d;
    logic signed [15:0] acc;
    d   = $signed({2'b00, nw}) - $signed({2'b00, ow});
    acc = $signed({8'h00, ow}) + (($signed({11'h000, k}) * 16'(lf)) >>> 4)
          + 16'(d - lf);
    if (acc < 0) return 8'h00;
    if (acc > $signed({8'h00, mx})) return mx;
    return acc[7:0];
  endfunction

  logic signed [9:0]  yd, cd, ylf, clf;
  logic        [8:0]  ymag, cmag;
  logic        [4:0]  kc_own;
  logic        [7:0]  ymix, cmix;

  // Difference, band split, weight choice and blend
  always_comb begin
    yd   = $signed({2'b00, new_i[11:4]}) - $signed({2'b00, old_i[11:4]});
    cd   = $signed({6'h00, new_i[3:0]}) - $signed({6'h00, old_i[3:0]});
    ylf  = ctrl_i[fdnr_pkg::CTRL_UNFILT] ? yd : 10'((11'(yd) + 11'(yprev_i)) >>> 1); // RULE22
    clf  = ctrl_i[fdnr_pkg::CTRL_UNFILT] ? cd : 10'((11'(cd) + 11'(cprev_i)) >>> 1); // RULE22
    ymag = yd[9] ? 9'(-yd) : yd[8:0];
    cmag = cd[9] ? 9'(-cd) : cd[8:0];
    kluma_o = ctrl_i[fdnr_pkg::CTRL_LUMAFIX] ?                             // RULE19
              k_fix(kfix_i[fdnr_pkg::KFIX_LUMA_LSB +: 4]) : k_lut(ymag, kstep_i); // RULE20
    kc_own  = ctrl_i[fdnr_pkg::CTRL_CHROMAFIX] ?                           // RULE19
              k_fix(kfix_i[fdnr_pkg::KFIX_CHROMA_LSB +: 4]) : k_lut(cmag, kstep_i); // RULE20
    kchroma_o = (ctrl_i[fdnr_pkg::CTRL_L2C] & ~ctrl_i[fdnr_pkg::CTRL_CHROMAFIX]) ?
                kluma_o : kc_own; // RULE21
    ymix  = mix(new_i[11:4], old_i[11:4], kluma_o, ylf, 8'hff); // RULE24
    cmix  = mix({4'h0, new_i[3:0]}, {4'h0, old_i[3:0]}, kchroma_o, clf, 8'h0f); // RULE24
    mix_o = {ymix, cmix[3:0]};
    ydiff_o = yd;
    cdiff_o = cd;
  end
endmodule // fdnr_blend

// ### tb/fdnr_ctrl_model.sv
// Purpose: Video controller model driving both link clocks and strobes
// Assumes: Link clocks stand still low between calls; pins change after clk_i edges
// Notes:   The bench calls the cycle tasks through the instance
`timescale 1ns/1ns
module fdnr_ctrl_model #(
  parameter int PWR_CYC = 12500
) (
  input  wire logic        clk_i,
  output logic             serial_write_clock_o,
  output logic             wr_en_o,
  output logic             in_en_o,
  output logic             wr_ptr_clear_o,
  output logic      [11:0] in_bus_o,
  output logic             serial_read_clock_o,
  output logic             rd_advance_en_o,
  output logic             out_drive_o,
  output logic             rd_ptr_clear_o
);
  int half_w = 4;
  // Idle pins at time zero
  initial begin
    {serial_write_clock_o, wr_en_o, in_en_o, wr_ptr_clear_o} = 4'h0;
    {serial_read_clock_o, rd_advance_en_o, out_drive_o, rd_ptr_clear_o} = 4'h0;
    in_bus_o = 12'h000;
  end
  // One write clock period; data bus shows the inverse once hold has passed
  task automatic wcyc(input logic we, input logic ie, input logic clr, input logic [11:0] d);
    @(posedge clk_i);
    wr_en_o <= we;
    in_en_o <= ie;
    wr_ptr_clear_o <= clr;
    in_bus_o <= d;
    repeat (half_w - 1) @(posedge clk_i);
    serial_write_clock_o <= 1'b1;
    repeat (half_w) @(posedge clk_i);
    serial_write_clock_o <= 1'b0;
    in_bus_o <= ~d;
  endtask
  // One read clock period, settled output on return
  task automatic rcyc(input logic adv, input logic drv, input logic clr);
    @(posedge clk_i);
    rd_advance_en_o <= adv;
    out_drive_o <= drv;
    rd_ptr_clear_o <= clr;
    repeat (3) @(posedge clk_i);
    serial_read_clock_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    serial_read_clock_o <= 1'b0;
  endtask
  // Power-up wait, then dummy cycles on both sides before any clear
  task automatic init;
    repeat (PWR_CYC) @(posedge clk_i);
    for (int i = 0; i < 12; i++) begin
      wcyc(1'b1, 1'b0, 1'b0, 12'h000);
      rcyc(1'b1, 1'b0, 1'b0);
    end
  endtask
endmodule // fdnr_ctrl_model

// ### tb/tb_field_fifo_read_and_denoise_ctrl.sv
// Purpose: Self-checking bench for the field FIFO read port and denoise control
// Assumes: Controller model drives link pins; bench drives Avalon and denoise level
// Notes:   Small array and fast refresh divider keep the run short
`timescale 1ns/1ns
module tb_field_fifo_read_and_denoise_ctrl;
  localparam int N = 24;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        denoise_on = 1'b0;
  logic        wck, we, ie, wclr, rck, radv, rdrv, rclr, doe, tmode;
  logic [11:0] din, dout;
  int          errors = 0;
  int          n_checks = 0;
  always #4 clk_i = ~clk_i;
  fdnr_fifo #(.ARRAY_WORDS(400), .REF_DIV(4)) u_fdnr_fifo (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .serial_write_clock_i(wck), .wr_en_i(we),
    .in_en_i(ie), .wr_ptr_clear_i(wclr), .in_bus_i(din), .denoise_on_i(denoise_on),
    .serial_read_clock_i(rck), .rd_advance_en_i(radv), .out_drive_i(rdrv),
    .rd_ptr_clear_i(rclr), .out_bus_o(dout), .out_bus_oe_o(doe), .test_mode_o(tmode));
  fdnr_ctrl_model u_fdnr_ctrl_model (
    .clk_i(clk_i), .serial_write_clock_o(wck), .wr_en_o(we), .in_en_o(ie),
    .wr_ptr_clear_o(wclr), .in_bus_o(din), .serial_read_clock_o(rck),
    .rd_advance_en_o(radv), .out_drive_o(rdrv), .rd_ptr_clear_o(rclr));
  // Word pattern of one field
  function automatic logic [11:0] w(input int i, input logic inv);
    return 12'(i * 389 + 12'h5a3) ^ {12{inv}};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_i);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    @(posedge clk_i);
    while (avs_waitrequest !== 1'b0) @(posedge clk_i);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Clear then write a field, then masked writes so it reaches the array
  task automatic fill(input logic inv);
    u_fdnr_ctrl_model.wcyc(1'b1, 1'b1, 1'b1, w(0, inv));
    for (int i = 1; i < N; i++) u_fdnr_ctrl_model.wcyc(1'b1, 1'b1, 1'b0, w(i, inv));
    repeat (40) u_fdnr_ctrl_model.wcyc(1'b1, 1'b0, 1'b0, 12'h000);
  endtask
  // Clear the read pointer and compare cnt words from the lowest address
  task automatic drain(input logic inv, input int cnt);
    u_fdnr_ctrl_model.rcyc(1'b1, 1'b1, 1'b1);
    check(32'(dout), 32'(w(0, inv)));
    for (int i = 1; i < cnt; i++) begin
      u_fdnr_ctrl_model.rcyc(1'b1, 1'b1, 1'b0);
      check(32'(dout), 32'(w(i, inv)));
    end
  endtask
  // Watchdog
  initial begin
    #500000;
    errors++;
    finish_test;
  end
  // Main sequence
  initial begin
    logic [31:0] d, s;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'({doe, tmode}), 32'h0);
    bus(1'b0, fdnr_pkg::CTRL_OFS, 32'h0, d);
    check(d, 32'(fdnr_pkg::CTRL_RST));
    bus(1'b0, fdnr_pkg::KFIX_OFS, 32'h0, d);
    check(d, 32'(fdnr_pkg::KFIX_RST));
    bus(1'b0, fdnr_pkg::KSTEP_OFS, 32'h0, d);
    check(d, fdnr_pkg::KSTEP_RST);
    bus(1'b0, 4'h2, 32'h0, d);
    check(d, 32'h0);
    // Refresh counter runs, and stops when refresh is switched off
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, fdnr_pkg::CTRL_OFS, 32'(k), d);
      bus(1'b0, fdnr_pkg::STAT_OFS, 32'h0, s);
      repeat (64) @(posedge clk_i);
      bus(1'b0, fdnr_pkg::STAT_OFS, 32'h0, d);
      check(32'(s[28:16] == d[28:16]), 32'(k));
    end
    bus(1'b1, fdnr_pkg::CTRL_OFS, 32'h0, d);
    u_fdnr_ctrl_model.init();
    fill(1'b0);
    drain(1'b0, N - 5);
    // Advance low holds, drive low steps unseen, drive high resumes
    repeat (2) u_fdnr_ctrl_model.rcyc(1'b0, 1'b1, 1'b0);
    check(32'(dout), 32'(w(N - 6, 1'b0)));
    repeat (3) u_fdnr_ctrl_model.rcyc(1'b1, 1'b0, 1'b0);
    check(32'(doe), 32'h0);
    u_fdnr_ctrl_model.rcyc(1'b1, 1'b1, 1'b0);
    check(32'({doe, dout}), 32'({1'b1, w(N - 2, 1'b0)}));
    // Denoise rising edge reloads defaults
    bus(1'b1, fdnr_pkg::CTRL_OFS, 32'h1f, d);
    bus(1'b1, fdnr_pkg::KFIX_OFS, 32'h12, d);
    @(posedge clk_i);
    denoise_on <= 1'b1;
    repeat (10) @(posedge clk_i);
    bus(1'b0, fdnr_pkg::CTRL_OFS, 32'h0, d);
    check(d, 32'(fdnr_pkg::CTRL_RST));
    bus(1'b0, fdnr_pkg::KFIX_OFS, 32'h0, d);
    check(d, 32'(fdnr_pkg::KFIX_RST));
    bus(1'b0, fdnr_pkg::STAT_OFS, 32'h0, d);
    check(32'(d[fdnr_pkg::STAT_DEN]), 32'h1);
    // Fixed zero keeps old, fixed fifteen takes new, adaptive zero steps take new
    u_fdnr_ctrl_model.half_w = 8;
    bus(1'b1, fdnr_pkg::KSTEP_OFS, 32'h0, d);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, fdnr_pkg::CTRL_OFS, (k == 2) ? 32'h18 : 32'h16, d);
      bus(1'b1, fdnr_pkg::KFIX_OFS, k ? 32'hff : 32'h00, d);
      fill(1'(k != 2));
      drain(1'(k == 1), N);
    end
    @(posedge clk_i);
    denoise_on <= 1'b0;
    u_fdnr_ctrl_model.half_w = 4;
    // Test mode entry and both exits
    for (int k = 0; k < 2; k++) begin
      repeat (1023) u_fdnr_ctrl_model.wcyc(1'b1, 1'b0, 1'b1, 12'h000);
      check(32'(tmode), 32'h0);
      u_fdnr_ctrl_model.wcyc(1'b1, 1'b0, 1'b1, 12'h000);
      check(32'(tmode), 32'h1);
      bus(1'b0, fdnr_pkg::STAT_OFS, 32'h0, d);
      check(32'(d[fdnr_pkg::STAT_TEST]), 32'h1);
      if (k == 1) begin
        u_fdnr_ctrl_model.wcyc(1'b1, 1'b0, 1'b0, 12'h000);
        check(32'(tmode), 32'h1);
      end
      u_fdnr_ctrl_model.wcyc(1'(k), 1'b0, 1'b0, 12'h000);
      check(32'(tmode), 32'h0);
    end
    finish_test;
  end
endmodule // tb_field_fifo_read_and_denoise_ctrl
